// [design/sas_seq.sv]
// Purpose: control of a 10-bit successive-approximation converter with six inputs
// Assumes: comparator and ladder outside; one AXI4-Lite master; inputs synchronous to REF_CLK
// Notes: the analog ladder is offset by half a step so a trial code n compares at (n - 0.5) LSB
//
// Summary of operation
// - conversions repeat back to back until software clears the enable bit (bit 7)
// - writing mode or channel register aborts a running conversion; restart if enabled
// - the result register has no defined value after reset
// - code equals integer part of input/reference times 1024 plus one half
// - only select mode: channel register picks one of six inputs
// - no hardware trigger; only a mode register write starts conversion
// - setting the enable bit starts converting the selected input
// - end of conversion loads result and raises done request together
// - after completion the next conversion starts on the same channel automatically
// - mode write with enable set discards conversion, restarts with new settings
// - mode write with enable clear halts conversion at once, no result
// - standby freezes the sequencer; no conversion steps
// - result read colliding with update returns old value, update follows
// - mode/channel write colliding with end of conversion wins; no update, no request
// - writing the mode register leaves the done flag unchanged
// - result is 16 bits, code in bits 15..6, low six bits zero
// - time field codes 000,001,010,100 give 144,120,96,72 periods
// - channel codes 000..101 pick inputs 0..5; upper register bits zero
// - trial each bit 9 down to 0; keep when input at or above tap
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_seq #(
    parameter int ADDR_W = 16
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic STANDBY,
    input wire logic COMP_GE,
    output logic [2:0] CHANNEL_SEL,
    output logic SAMPLE_HOLD_N,
    output logic [9:0] TAP_CODE,
    output logic CONV_DONE_IRQ,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 16) begin : g_bad_addr
        $error("sas_seq: ADDR_W must be at least 16");
    end

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // prohibited time codes fall back to the slowest setting, the safe side
    function automatic logic [7:0] slot_len(input logic [2:0] code);
        case (code)
            3'h1: slot_len = 8'(`SAS_CONV_001 / `SAS_SLOTS);
            3'h2: slot_len = 8'(`SAS_CONV_010 / `SAS_SLOTS);
            3'h4: slot_len = 8'(`SAS_CONV_100 / `SAS_SLOTS);
            default: slot_len = 8'(`SAS_CONV_000 / `SAS_SLOTS);
        endcase
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // ----------------------------------------------------------------
    // bus slave: address and data are held separately, write acts once both are in
    // ----------------------------------------------------------------
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    sas_pkg::sas_wreq_t wreq_ff;

    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire lane0 = wreq_ff.strb[0];
    wire wr_mode = wr_fire && lane0 && hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_MODE);
    wire wr_chan = wr_fire && lane0 && hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_CHAN);
    wire wr_flag = wr_fire && lane0 && hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_FLAG);
    wire wr_known = hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_MODE) || hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_CHAN)
        || hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_FLAG) || hit(ADDR_W'(wreq_ff.addr), `SAS_OFS_RESULT);
    wire ctl_wr = wr_mode || wr_chan;

    assign S_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
    assign S_AXI_WREADY = !w_got_ff && !bvalid_ff;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign S_AXI_RDATA = rdata_ff;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SAS_RESP_OKAY;
            wreq_ff <= '0;
        end else begin
            if (aw_take) begin
                aw_got_ff <= 1'b1;
                wreq_ff.addr <= S_AXI_AWADDR[15:0];
            end
            if (w_take) begin
                w_got_ff <= 1'b1;
                wreq_ff.data <= S_AXI_WDATA;
                wreq_ff.strb <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_known ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic en_ff;
    logic [2:0] time_ff, chan_ff;
    logic flag_ff;

    wire nxt_en = wreq_ff.data[`SAS_MODE_EN_BIT];
    wire [2:0] nxt_time = wreq_ff.data[`SAS_MODE_TIME_LSB +: 3];

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_ff <= 1'(`SAS_MODE_RST >> `SAS_MODE_EN_BIT);
            time_ff <= 3'(`SAS_MODE_RST >> `SAS_MODE_TIME_LSB);
            chan_ff <= `SAS_CHAN_RST;
        end else begin
            if (wr_mode) begin
                en_ff <= nxt_en;
                time_ff <= nxt_time;
            end
            if (wr_chan) begin
                chan_ff <= wreq_ff.data[2:0]; // upper bits are not stored
            end
        end
    end

    assign CHANNEL_SEL = chan_ff;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    sas_pkg::sas_state_t state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [3:0] bit_ff, nxt_bit;
    logic [9:0] sar_ff, nxt_sar;
    logic [9:0] code_ff;
    logic irq_ff;

    wire [7:0] slot = slot_len(wr_mode ? nxt_time : time_ff);
    wire [7:0] sample_len = 8'(slot * `SAS_SAMPLE_SLOTS);
    wire cnt_end = (cnt_ff == 8'h01);
    wire [9:0] sar_kept = COMP_GE ? sar_ff : (sar_ff & ~(10'h001 << bit_ff));
    wire conv_end = !STANDBY && (state_ff == sas_pkg::SAS_CONVERT) && cnt_end && (bit_ff == 4'h0);
    wire done_evt = conv_end && !ctl_wr;
    wire run_next = wr_mode ? nxt_en : en_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_sar = sar_ff;
        if (ctl_wr) begin
            // abort whatever runs; a channel write alone never starts an idle converter
            if (run_next && (wr_mode || state_ff != sas_pkg::SAS_IDLE)) begin
                nxt_state = sas_pkg::SAS_SAMPLE;
                nxt_cnt = sample_len;
            end else begin
                nxt_state = sas_pkg::SAS_IDLE;
            end
        end else if (!STANDBY) begin
            case (state_ff)
                sas_pkg::SAS_IDLE: begin
                    nxt_state = sas_pkg::SAS_IDLE;
                end
                sas_pkg::SAS_SAMPLE: begin
                    if (cnt_end) begin
                        nxt_state = sas_pkg::SAS_CONVERT;
                        nxt_cnt = slot;
                        nxt_bit = `SAS_SAR_TOP_BIT;
                        nxt_sar = `SAS_SAR_MSB_TRIAL;
                    end else begin
                        nxt_cnt = cnt_ff - 8'h01;
                    end
                end
                sas_pkg::SAS_CONVERT: begin
                    if (!cnt_end) begin
                        nxt_cnt = cnt_ff - 8'h01;
                    end else if (bit_ff == 4'h0) begin
                        nxt_sar = sar_kept;
                        nxt_state = sas_pkg::SAS_SAMPLE;
                        nxt_cnt = sample_len;
                    end else begin
                        nxt_bit = bit_ff - 4'h1;
                        nxt_sar = sar_kept | (10'h001 << (bit_ff - 4'h1));
                        nxt_cnt = slot;
                    end
                end
                default: begin
                    nxt_state = sas_pkg::SAS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= sas_pkg::SAS_IDLE;
            cnt_ff <= 8'h00;
            bit_ff <= 4'h0;
            sar_ff <= 10'h000;
            irq_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sar_ff <= nxt_sar;
            irq_ff <= done_evt;
            // set beats clear; mode writes leave the flag alone
            if (done_evt) begin
                flag_ff <= 1'b1;
            end else if (wr_flag && wreq_ff.data[0]) begin
                flag_ff <= 1'b0;
            end
        end
    end

    // no reset: the result is meaningless until the first conversion ends
    always_ff @(posedge REF_CLK) begin
        if (done_evt) begin
            code_ff <= sar_kept;
        end
    end

    assign TAP_CODE = sar_ff;
    assign SAMPLE_HOLD_N = (state_ff != sas_pkg::SAS_SAMPLE);
    assign CONV_DONE_IRQ = irq_ff;

    // ----------------------------------------------------------------
    // read path: data is captured at the same edge as any update, so it holds the old result
    // ----------------------------------------------------------------
    wire [31:0] rd_mux =
        hit(S_AXI_ARADDR, `SAS_OFS_RESULT) ? {16'h0000, code_ff, 6'h00} :
        hit(S_AXI_ARADDR, `SAS_OFS_MODE) ? {24'h000000, en_ff, 1'b0, time_ff, 3'h0} :
        hit(S_AXI_ARADDR, `SAS_OFS_CHAN) ? {29'h00000000, chan_ff} :
        hit(S_AXI_ARADDR, `SAS_OFS_FLAG) ? {31'h00000000, flag_ff} : 32'h00000000;
    wire rd_known = hit(S_AXI_ARADDR, `SAS_OFS_RESULT) || hit(S_AXI_ARADDR, `SAS_OFS_MODE)
        || hit(S_AXI_ARADDR, `SAS_OFS_CHAN) || hit(S_AXI_ARADDR, `SAS_OFS_FLAG);
    logic rd_res_ff;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `SAS_RESP_OKAY;
            rd_res_ff <= 1'b0;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_known ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
            rd_res_ff <= hit(S_AXI_ARADDR, `SAS_OFS_RESULT);
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_done_clean;
        conv_end && !ctl_wr;
    endsequence

    property p_stop_on_clear;
        @(posedge REF_CLK) disable iff (!ARST_N) wr_mode && !nxt_en |=> state_ff == sas_pkg::SAS_IDLE ##1 !irq_ff;
    endproperty
    a_stop_on_clear: assert property (p_stop_on_clear) else $error("clear of enable did not halt");

    property p_restart;
        @(posedge REF_CLK) disable iff (!ARST_N)
            wr_mode && nxt_en |=> state_ff == sas_pkg::SAS_SAMPLE && cnt_ff == 8'(slot_len(time_ff) * 2);
    endproperty
    a_restart: assert property (p_restart) else $error("enabled mode write did not restart sampling");

    property p_chan_abort;
        @(posedge REF_CLK) disable iff (!ARST_N)
            wr_chan && !wr_mode && en_ff && state_ff != sas_pkg::SAS_IDLE |=> state_ff == sas_pkg::SAS_SAMPLE;
    endproperty
    a_chan_abort: assert property (p_chan_abort) else $error("channel write did not restart");

    property p_load_with_irq;
        @(posedge REF_CLK) disable iff (!ARST_N)
            s_done_clean |=> irq_ff && flag_ff && code_ff == $past(sar_kept) ##1 !irq_ff;
    endproperty
    a_load_with_irq: assert property (p_load_with_irq) else $error("result and request not together");

    property p_write_wins;
        @(posedge REF_CLK) disable iff (!ARST_N) conv_end && ctl_wr |=> !irq_ff && $stable(code_ff);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("update despite register write");

    property p_auto_next;
        @(posedge REF_CLK) disable iff (!ARST_N)
            s_done_clean |=> state_ff == sas_pkg::SAS_SAMPLE && CHANNEL_SEL == $past(chan_ff);
    endproperty
    a_auto_next: assert property (p_auto_next) else $error("no automatic next conversion");

    property p_flag_kept;
        @(posedge REF_CLK) disable iff (!ARST_N) flag_ff && wr_mode |=> flag_ff;
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("mode write cleared the flag");

    property p_standby;
        @(posedge REF_CLK) disable iff (!ARST_N)
            STANDBY && !ctl_wr |=> $stable(state_ff) && $stable(cnt_ff) && $stable(sar_ff) && !irq_ff;
    endproperty
    a_standby: assert property (p_standby) else $error("sequencer moved in standby");

    property p_no_trigger;
        @(posedge REF_CLK) disable iff (!ARST_N) state_ff == sas_pkg::SAS_IDLE && !wr_mode |=> $stable(state_ff);
    endproperty
    a_no_trigger: assert property (p_no_trigger) else $error("conversion started without mode write");

    property p_low_zero;
        @(posedge REF_CLK) disable iff (!ARST_N) rvalid_ff && rd_res_ff |-> !(|rdata_ff[31:16]) && !(|rdata_ff[5:0]);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("result low bits not zero");

    property p_step_len;
        @(posedge REF_CLK) disable iff (!ARST_N)
            state_ff == sas_pkg::SAS_CONVERT |-> cnt_ff <= slot_len(time_ff) && cnt_ff != 8'h00;
    endproperty
    a_step_len: assert property (p_step_len) else $error("comparison step length wrong");

endmodule // sas_seq

// [pkg/sas_params.svh]
// Purpose: offsets, field positions, reset values and timing counts of the converter sequencer
// Assumes: byte addresses on a 32-bit register bus, one aligned word per register
// Notes: conversion periods are counted in main clock periods
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SAS_OFS_MODE 16'hFF80
`define SAS_OFS_CHAN 16'hFF84
`define SAS_OFS_RESULT 16'hFF14
`define SAS_OFS_FLAG 16'hFF88

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SAS_MODE_EN_BIT 7
`define SAS_MODE_TIME_LSB 3
`define SAS_MODE_RST 8'h00
`define SAS_CHAN_RST 3'h0
`define SAS_RES_LSB 6
`define SAS_SAR_MSB_TRIAL 10'h200
`define SAS_SAR_TOP_BIT 4'h9

// ----------------------------------------------------------------
// timing: periods per conversion, split into 12 equal slots
// ----------------------------------------------------------------
`define SAS_CONV_000 144
`define SAS_CONV_001 120
`define SAS_CONV_010 96
`define SAS_CONV_100 72
`define SAS_SLOTS 12
`define SAS_SAMPLE_SLOTS 2

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define SAS_RESP_OKAY 2'h0
`define SAS_RESP_SLVERR 2'h2

`endif

// [pkg/sas_pkg.sv]
// Purpose: types shared by the converter sequencer
// Assumes: nothing beyond the params header
// Notes: states are gray coded along idle, sample, convert
package sas_pkg;

    typedef enum logic [1:0] {
        SAS_IDLE = 2'h0,
        SAS_SAMPLE = 2'h1,
        SAS_CONVERT = 2'h3
    } sas_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } sas_wreq_t;

endpackage

// [verification/sas_ladder_model.sv]
// Purpose: comparator and ladder facing the converter sequencer
// Assumes: inputs given in half-step units, full scale is the reference
// Notes: tracks the input while sampling and holds it otherwise
`timescale 1ns/1ps

module sas_ladder_model (
    input wire logic clk,
    input wire logic [5:0][10:0] vin_x2,
    input wire logic [2:0] chan,
    input wire logic sample_hold_n,
    input wire logic [9:0] tap,
    output logic comp_ge
);
    logic [10:0] held_ff;

    // ----------------------------------------------------------------
    // sample and hold
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!sample_hold_n) begin
            held_ff <= vin_x2[chan];
        end
    end

    // ----------------------------------------------------------------
    // comparator
    // ----------------------------------------------------------------
    // taps sit half a step low, so the code rounds to nearest
    assign comp_ge = ({1'b0, held_ff} + 12'h001) >= {1'b0, tap, 1'b0};
endmodule // sas_ladder_model

// [verification/sas_seq_tb_top.sv]
// Purpose: self-checking bench of the converter sequencer
// Assumes: ladder model on the analog side, one bus master here
// Notes: input levels are in half-step units
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_seq_tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic standby = 1'b0;
    logic comp_ge, sh_n, irq, awready, wready, bvalid, arready, rvalid;
    logic [2:0] chan_sel;
    logic [9:0] tap;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, data;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, resp;
    logic [5:0][10:0] vin = {11'h555, 11'h2AB, 11'h3E8, 11'h001, 11'h7FE, 11'h000};
    int errors = 0;
    int total_checks = 0;
    int irq_cnt = 0;
    int n, c0;

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irq === 1'b1) irq_cnt++;

    sas_seq #(.ADDR_W(16)) DUT (.REF_CLK(ref_clk), .ARST_N(arst_n), .STANDBY(standby), .COMP_GE(comp_ge),
        .CHANNEL_SEL(chan_sel), .SAMPLE_HOLD_N(sh_n), .TAP_CODE(tap), .CONV_DONE_IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));

    sas_ladder_model ladder (.clk(ref_clk), .vin_x2(vin), .chan(chan_sel), .sample_hold_n(sh_n), .tap(tap),
        .comp_ge(comp_ge));

    // ----------------------------------------------------------------
    // compare and closing
    // ----------------------------------------------------------------
    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("MISMATCH %0t count %0d expected %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // bus master
    // ----------------------------------------------------------------
    // readies only move at rising edges, so the falling edge sees what the next edge samples
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic pa, pw, pb, ha, hw, hb;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw || pb) begin
            @(negedge ref_clk);
            ha = pa && awready;
            hw = pw && wready;
            hb = pb && bvalid;
            if (hb) resp = bresp;
            @(posedge ref_clk);
            awvalid <= pa && !ha;
            wvalid <= pw && !hw;
            bready <= pb && !hb;
            pa = pa && !ha;
            pw = pw && !hw;
            pb = pb && !hb;
        end
    endtask

    task automatic rd(input logic [15:0] a);
        logic pa, pb, ha, hb;
        pa = 1'b1;
        pb = 1'b1;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (pa || pb) begin
            @(negedge ref_clk);
            ha = pa && arready;
            hb = pb && rvalid;
            if (hb) data = rdata;
            if (hb) resp = rresp;
            @(posedge ref_clk);
            arvalid <= pa && !ha;
            rready <= pb && !hb;
            pa = pa && !ha;
            pb = pb && !hb;
        end
    endtask

    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < lim);
    endtask

    task automatic start(input logic [2:0] ch, input logic [2:0] tc);
        wr(`SAS_OFS_FLAG, 32'h1);
        wr(`SAS_OFS_CHAN, {29'h0, ch});
        wr(`SAS_OFS_MODE, {24'h0, 1'b1, 1'b0, tc, 3'h0});
    endtask

    function automatic logic [31:0] code_of(input logic [10:0] v);
        return ((({21'h0, v} + 32'h1) >> 1) << `SAS_RES_LSB);
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(`SAS_OFS_MODE);
        chk_v(data, 32'h0);
        rd(`SAS_OFS_CHAN);
        chk_v(data, 32'h0);
        rd(`SAS_OFS_FLAG);
        chk_v(data, 32'h0);
        rd(16'hFF90);
        chk_v({30'h0, resp}, {30'h0, `SAS_RESP_SLVERR});
        chk_v(data, 32'h0);
        wr(16'hFF90, 32'hFFFFFFFF);
        chk_v({30'h0, resp}, {30'h0, `SAS_RESP_SLVERR});
    endtask

    task automatic t_convert();
        logic [2:0] tc [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        int per [4] = '{144, 120, 96, 72};
        for (int i = 0; i < 6; i++) begin
            start(3'(i), tc[i % 4]);
            chk_v({29'h0, chan_sel}, i);
            wait_irq(400);
            wait_irq(400);
            chk_n(n, per[i % 4], per[i % 4]);
            rd(`SAS_OFS_RESULT);
            chk_v(data, code_of(vin[i]));
            rd(`SAS_OFS_FLAG);
            chk_v(data, 32'h1);
            wr(`SAS_OFS_MODE, {24'h0, 1'b1, 1'b0, tc[i % 4], 3'h0});
            rd(`SAS_OFS_FLAG);
            chk_v(data, 32'h1);
        end
    endtask

    task automatic t_abort();
        start(3'h3, 3'h4);
        wait_irq(400);
        repeat (30) @(posedge ref_clk);
        wr(`SAS_OFS_MODE, 32'h80);
        wait_irq(400);
        chk_n(n, 142, 144);
        repeat (50) @(posedge ref_clk);
        wr(`SAS_OFS_CHAN, 32'h5);
        wait_irq(400);
        chk_n(n, 142, 144);
        repeat (40) @(posedge ref_clk);
        wr(`SAS_OFS_MODE, 32'h0);
        wait_irq(400);
        chk_n(n, 400, 400);
        rd(`SAS_OFS_RESULT);
        c0 = data;
        wr(`SAS_OFS_RESULT, 32'hFFFF);
        chk_v({30'h0, resp}, {30'h0, `SAS_RESP_OKAY});
        rd(`SAS_OFS_RESULT);
        chk_v(data, c0);
        wr(`SAS_OFS_CHAN, 32'h2);
        wait_irq(400);
        chk_n(n, 400, 400);
    endtask

    task automatic t_standby();
        start(3'h1, 3'h7);
        wait_irq(400);
        repeat (20) @(posedge ref_clk);
        standby <= 1'b1;
        wait_irq(500);
        chk_n(n, 500, 500);
        @(posedge ref_clk);
        standby <= 1'b0;
        wait_irq(400);
        chk_n(n, 115, 130);
    endtask

    task automatic t_collide();
        start(3'h4, 3'h2);
        wait_irq(400);
        rd(`SAS_OFS_RESULT);
        c0 = data;
        wait_irq(400);
        vin[4] = 11'h100;
        repeat (93) @(posedge ref_clk);
        n = irq_cnt;
        wr(`SAS_OFS_MODE, 32'h90);
        repeat (2) @(posedge ref_clk);
        chk_n(irq_cnt - n, 0, 0);
        rd(`SAS_OFS_RESULT);
        chk_v(data, c0);
        wait_irq(400);
        vin[4] = 11'h001;
        rd(`SAS_OFS_RESULT);
        chk_v(data, code_of(11'h100));
        repeat (91) @(posedge ref_clk);
        rd(`SAS_OFS_RESULT);
        chk_v(data, code_of(11'h100));
        rd(`SAS_OFS_RESULT);
        chk_v(data, code_of(11'h001));
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_convert();
        t_abort();
        t_standby();
        t_collide();
        test_done();
    end

    // the whole run takes some 4200 cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        $display("MISMATCH %0t run did not finish", $time);
        test_done();
    end
endmodule // sas_seq_tb_top
